// *** lvds_rx_pkg.sv ***
// Constants and carrier types of the four-lane serial video receiver.
// Assumes one system clock at 100 MHz and a separate bit-rate link clock.
package lvds_rx_pkg;

   localparam int LANES         = 4;                // Serial data lanes
   localparam int SLOTS         = 7;                // Bit slots per link clock period
   localparam int SLOT_W        = 3;                // Width of the slot counter
   localparam int COLOR_W       = 8;                // Bits per colour
   localparam int WORD_W        = LANES * SLOTS;    // Parallel bits per period
   localparam int HIGH_SLOTS    = 4;                // Bit times the pixel clock stays high
   localparam int CLK_MHZ       = 100;              // System clock rate
   localparam int LOCK_TIME_MS  = 10;               // Longest lock interval
   localparam int LOCK_CYC      = LOCK_TIME_MS * 1000 * CLK_MHZ;  // Lock interval in cycles
   localparam int PD_DELAY_US   = 1;                // Longest power-down entry
   localparam int PD_DELAY_CYC  = PD_DELAY_US * CLK_MHZ;          // Entry bound in cycles
   localparam int PERIOD_MIN_NS = 15;               // Shortest link clock period
   localparam int PERIOD_MAX_NS = 50;               // Longest link clock period
   localparam int ACT_WIN_CYC   = 4 * PERIOD_MAX_NS * CLK_MHZ / 1000;  // Activity window
   localparam int ACT_W         = 5;                // Width of the activity watchdog

   // Pins and lock flag sampled in the link domain
   typedef struct packed {
      logic             locked;                     // Lock flag from system domain
      logic             clk_lane;                   // Forwarded clock lane level
      logic [LANES-1:0] data;                       // Data lane levels
   } lane_in_t;

   // One parallel word; bit n is lane n/7, slot n%7
   typedef struct packed {
      logic               spare;                    // Spare control bit
      logic               data_enable_flag;         // Data enable
      logic               frame_sync;               // Frame sync
      logic               line_sync;                // Line sync
      logic [COLOR_W-1:0] blue;                     // Blue colour bits
      logic [COLOR_W-1:0] green;                    // Green colour bits
      logic [COLOR_W-1:0] red;                      // Red colour bits
   } pixel_word_t;

   // State of the link-domain logic
   typedef struct packed {
      logic              clk_prev;                  // Clock lane level one bit ago
      logic [SLOT_W-1:0] slot;                      // Bits gathered since last clock rise
      logic              ovr;                       // Period ran longer than seven bits
      logic [WORD_W-1:0] acc;                       // Word being gathered
      pixel_word_t       word;                      // Word on the outputs
      logic [SLOT_W-1:0] phase;                     // Pixel clock high-phase counter
      logic              pclk;                      // Regenerated pixel clock
      logic              tgl;                       // Toggles once per whole period
   } link_state_t;

endpackage : lvds_rx_pkg

// *** lvds_sync2.sv ***
// Two flip-flop level synchroniser, also used as a reset synchroniser.
// Assumes d is a level; the first stage feeds nothing but the second.
`timescale 1ns/1ns
module lvds_sync2 #(
   parameter int           W       = 1,            // Bits synchronised
   parameter logic [W-1:0] RST_VAL = '0             // Value held in reset
) (
   input  wire logic         clk,                   // Destination clock
   input  wire logic         arst_n,                // Asynchronous reset, active low
   input  wire logic [W-1:0] d,                     // Level from another domain
   output logic      [W-1:0] q                      // Synchronised level
);

   typedef struct packed {
      logic [W-1:0] meta;                           // First stage
      logic [W-1:0] stable;                         // Second stage
   } sync_t;

   sync_t st_r;                                     // Registered state
   sync_t st_nxt;                                   // Next state

   // Shift the level through both stages
   always_comb begin
      st_nxt        = st_r;
      st_nxt.meta   = d;
      st_nxt.stable = st_r.meta;
   end

   // Both stages take the reset value at once
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= {RST_VAL, RST_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.stable;

endmodule : lvds_sync2

// *** lvds_video_deserializer_rx.sv ***
// Four-lane serial video receiver: seven slots per lane per period, 28-bit word out.
// Assumes link_clk runs at seven times the forwarded clock, one edge per bit slot,
// and that the forwarded clock lane rises at the start of bit slot 0.
`timescale 1ns/1ns

// How it works
// - Seven bit slots sampled per lane per period
// - Word carries 24 colour bits plus syncs
// - Pixel clock falling edge strobes the word
// - Power-down holds every output low
// - Pixel clock period follows forwarded clock period
// - Outputs quiet until lock interval completes
// - Power-down entry takes effect within 1 us
// - Pixel clock high four slots, low three
// - Forwarded clock lane frames all data lanes
module lvds_video_deserializer_rx #(
   parameter int LOCK_CYCLES = lvds_rx_pkg::LOCK_CYC  // Lock interval in clk cycles
) (
   input  wire logic                              clk,               // System clock
   input  wire logic                              arst_n,            // Reset, active low
   input  wire logic                              link_clk,          // Bit-rate link clock
   input  wire logic [lvds_rx_pkg::LANES-1:0]     serial_data_lane,  // Data lanes
   input  wire logic                              link_clock_in,     // Forwarded clock lane
   input  wire logic                              power_down_n,      // Power-down, active low
   output lvds_rx_pkg::pixel_word_t               parallel_data_out, // Parallel word
   output logic                                   pixel_clock_out,   // Regenerated clock
   output logic                                   lock_status        // Lock achieved
);

   localparam int LOCK_CNT_W = $clog2(LOCK_CYCLES + 1);   // Lock counter width
   localparam int PD_BOUND   = lvds_rx_pkg::PD_DELAY_CYC; // Power-down entry bound

   // State of the system-domain logic
   typedef struct packed {
      logic                               act_prev; // Activity toggle seen last cycle
      logic [lvds_rx_pkg::ACT_W-1:0]      wd;       // Cycles since last activity
      logic [LOCK_CNT_W-1:0]              cnt;      // Lock interval counter
      logic                               lock;     // Lock achieved
   } sys_state_t;

   // Crossing and reset wiring
   logic                    link_rst_raw_n;         // Reset or power-down, unsynchronised
   logic                    link_rst_n;             // Link-domain reset, released in step
   lvds_rx_pkg::lane_in_t   lane_raw;               // Pins and lock before sync
   lvds_rx_pkg::lane_in_t   lane_s;                 // Pins and lock after sync
   logic [1:0]              sys_s;                  // Power-down and activity after sync
   logic                    pd_s;                   // Power-down level, high when running
   logic                    act_s;                  // Activity toggle in system domain

   // Link-domain state
   lvds_rx_pkg::link_state_t link_r;                // Registered link state
   lvds_rx_pkg::link_state_t link_nxt;              // Next link state
   logic                     rise;                  // Forwarded clock lane rose
   logic                     full;                  // Exactly seven slots gathered
   logic                     cap_raw;               // Whole period ended
   logic                     cap;                   // Whole period ended while locked

   // System-domain state
   sys_state_t sys_r;                               // Registered system state
   sys_state_t sys_nxt;                             // Next system state
   logic       alive;                               // Forwarded clock is running
   logic       lock_done;                           // Lock counter at its last count

   // Power-down acts as an asynchronous reset of the link side, released in step
   assign link_rst_raw_n = arst_n & power_down_n;

   lvds_sync2 #(
      .W       (1),
      .RST_VAL (1'h0)
   ) u_link_rst (
      .clk    (link_clk),
      .arst_n (link_rst_raw_n),
      .d      (1'h1),
      .q      (link_rst_n)
   );

   // Lanes, clock lane and lock flag enter the link domain through two stages
   assign lane_raw.locked   = sys_r.lock;
   assign lane_raw.clk_lane = link_clock_in;
   assign lane_raw.data     = serial_data_lane;

   lvds_sync2 #(
      .W       ($bits(lvds_rx_pkg::lane_in_t)),
      .RST_VAL ('0)
   ) u_lane_sync (
      .clk    (link_clk),
      .arst_n (link_rst_n),
      .d      (lane_raw),
      .q      (lane_s)
   );

   // Power-down pin and activity toggle enter the system domain
   lvds_sync2 #(
      .W       (2),
      .RST_VAL (2'h0)
   ) u_sys_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      ({power_down_n, link_r.tgl}),
      .q      (sys_s)
   );

   assign pd_s  = sys_s[1];
   assign act_s = sys_s[0];

   // Link side: gather slots, frame on clock lane, regenerate pixel clock
   always_comb begin
      link_nxt = link_r;
      rise     = lane_s.clk_lane & ~link_r.clk_prev;
      full     = (link_r.slot == lvds_rx_pkg::SLOT_W'(lvds_rx_pkg::SLOTS)) & ~link_r.ovr;
      cap_raw  = rise & full;
      cap      = cap_raw & lane_s.locked;
      link_nxt.clk_prev = lane_s.clk_lane;
      if (rise) begin
         // Clock lane rose: this sample is slot 0 of a new period
         for (int l = 0; l < lvds_rx_pkg::LANES; l++) begin
            link_nxt.acc[l * lvds_rx_pkg::SLOTS] = lane_s.data[l];
         end
         link_nxt.slot = lvds_rx_pkg::SLOT_W'(1);
         link_nxt.ovr  = 1'h0;
      end else if (link_r.slot == lvds_rx_pkg::SLOT_W'(lvds_rx_pkg::SLOTS)) begin
         // An eighth slot without a clock rise spoils the period
         link_nxt.ovr = 1'h1;
      end else begin
         // Store the sample at its slot, lane-major
         for (int l = 0; l < lvds_rx_pkg::LANES; l++) begin
            link_nxt.acc[l * lvds_rx_pkg::SLOTS + int'(link_r.slot)] = lane_s.data[l];
         end
         link_nxt.slot = link_r.slot + lvds_rx_pkg::SLOT_W'(1);
      end
      // One toggle per whole period tells the system side the clock runs
      link_nxt.tgl = link_r.tgl ^ cap_raw;
      if (!lane_s.locked) begin
         // Not locked: word and clock stay low
         link_nxt.word  = '0;
         link_nxt.phase = '0;
      end else if (cap) begin
         // New word appears with the pixel clock rise
         link_nxt.word  = lvds_rx_pkg::pixel_word_t'(link_r.acc);
         link_nxt.phase = lvds_rx_pkg::SLOT_W'(1);
      end else if (link_r.phase != '0 &&
                   link_r.phase < lvds_rx_pkg::SLOT_W'(lvds_rx_pkg::HIGH_SLOTS)) begin
         // Still in the high phase
         link_nxt.phase = link_r.phase + lvds_rx_pkg::SLOT_W'(1);
      end else begin
         // Low phase until the next period
         link_nxt.phase = '0;
      end
      link_nxt.pclk = (link_nxt.phase != '0);
   end

   // Link registers; power-down clears them at once, except ovr, which it sets
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_r      <= '0;
         link_r.ovr  <= 1'h1;
      end else begin
         link_r <= link_nxt;
      end
   end

   // System side: watch clock activity and time the lock interval
   always_comb begin
      sys_nxt          = sys_r;
      alive            = (sys_r.wd != lvds_rx_pkg::ACT_W'(lvds_rx_pkg::ACT_WIN_CYC));
      lock_done        = (sys_r.cnt == LOCK_CNT_W'(LOCK_CYCLES - 1));
      sys_nxt.act_prev = act_s;
      if (act_s ^ sys_r.act_prev) begin
         // A whole period arrived
         sys_nxt.wd = '0;
      end else if (alive) begin
         // Count quiet cycles up to the window
         sys_nxt.wd = sys_r.wd + lvds_rx_pkg::ACT_W'(1);
      end
      if (!pd_s || !alive) begin
         // Powered down or no clock: start the lock interval again
         sys_nxt.cnt  = '0;
         sys_nxt.lock = 1'h0;
      end else if (!sys_r.lock) begin
         if (lock_done) begin
            // Interval complete
            sys_nxt.lock = 1'h1;
         end else begin
            // Still waiting
            sys_nxt.cnt = sys_r.cnt + LOCK_CNT_W'(1);
         end
      end
   end

   // System registers; watchdog starts expired so lock needs activity first
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sys_r    <= '0;
         sys_r.wd <= lvds_rx_pkg::ACT_W'(lvds_rx_pkg::ACT_WIN_CYC);
      end else begin
         sys_r <= sys_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign parallel_data_out = link_r.word;
   assign pixel_clock_out   = link_r.pclk;
   assign lock_status       = sys_r.lock;

   // A clock rise always restarts slot counting at slot 1
   chk_slot_restart: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      rise |=> (link_r.slot == 3'h1))
      else $error("slot count did not restart on clock lane rise");

   // Pixel clock high for four link bits
   chk_pclk_high: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $rose(pixel_clock_out) |-> pixel_clock_out[*4] ##1 !pixel_clock_out)
      else $error("pixel clock high phase not four bits");

   // Captures are a whole period apart
   chk_cap_spacing: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      cap |=> !cap[*6])
      else $error("period shorter than seven bits accepted");

   // Word changes only with a pixel clock rise or on unlock
   chk_word_stable: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $changed(parallel_data_out) |-> ($rose(pixel_clock_out) || !$past(lane_s.locked)))
      else $error("word changed away from pixel clock rise");

   // Word steady through the falling strobe
   chk_strobe_setup: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $fell(pixel_clock_out) |-> ($stable(parallel_data_out) && $past(pixel_clock_out, 4)))
      else $error("word not steady at falling strobe");

   // Unlocked receiver drives nothing
   chk_unlock_out: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      !lane_s.locked |=> (parallel_data_out == '0 && !pixel_clock_out))
      else $error("outputs active without lock");

   // Power-down pin forces outputs low
   chk_pd_out: assert property (@(posedge link_clk) disable iff (!arst_n)
      !power_down_n |-> (parallel_data_out == '0 && !pixel_clock_out))
      else $error("outputs not low in power-down");

   // Power-down drops lock within the entry bound
   chk_pd_unlock: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(pd_s) |-> ##[1:PD_BOUND] !lock_status)
      else $error("lock held after power-down");

   // Pixel clock rises only after a clock-lane framed capture
   chk_frame_align: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $rose(pixel_clock_out) |-> $past(rise))
      else $error("pixel clock rose without clock lane rise");

   // Lock is declared only after the full interval
   chk_lock_wait: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(lock_status) |-> ($past(lock_done) && $past(pd_s)))
      else $error("lock declared before interval end");

endmodule : lvds_video_deserializer_rx

// *** lvds_tx_model.sv ***
// Behavioural serialising transmitter that drives the receiver's lanes.
// Assumes link_clk is the bit clock; en and word change only in the system domain.
`timescale 1ns/1ns
module lvds_tx_model (
   input  wire logic                          link_clk,         // Bit clock
   input  wire logic                          en,               // Send frames while high
   input  wire lvds_rx_pkg::pixel_word_t      word,             // Word for the next period
   output logic [lvds_rx_pkg::LANES-1:0]      serial_data_lane, // Data lanes
   output logic                               link_clock_in     // Forwarded clock lane
);
   logic [2:0]                   slot_r;                        // Slot being sent
   lvds_rx_pkg::pixel_word_t     cur_r;                         // Word of this period
   lvds_rx_pkg::pixel_word_t     w;                             // Word used for this slot

   // Slot 0 takes a fresh word, the others keep the latched one
   assign w = (slot_r == 3'h0) ? word : cur_r;

   // One bit per lane per edge, clock lane high for the first four slots
   always_ff @(posedge link_clk) begin
      if (!en) begin
         slot_r           <= 3'h0;
         cur_r            <= word;
         serial_data_lane <= '0;
         link_clock_in    <= 1'b0;
      end else begin
         slot_r <= (slot_r == 3'h6) ? 3'h0 : slot_r + 3'h1;
         if (slot_r == 3'h0) begin
            cur_r <= word;
         end
         for (int l = 0; l < lvds_rx_pkg::LANES; l++) begin
            serial_data_lane[l] <= w[l*7 + int'(slot_r)];
         end
         link_clock_in <= (slot_r < 3'h4);
      end
   end
endmodule : lvds_tx_model

// *** lvds_video_deserializer_rx_tb.sv ***
// Self-checking bench of the serial video receiver with a transmitter model.
// Assumes a 100 MHz system clock and a 12 ns bit clock, unrelated in phase.
`timescale 1ns/1ns
module lvds_video_deserializer_rx_tb;
   localparam int LINK_NS = 12;                                 // Bit clock period
   localparam int LOW_NS  = (lvds_rx_pkg::SLOTS - lvds_rx_pkg::HIGH_SLOTS) * LINK_NS; // Low time
   logic                          clk;                          // System clock
   logic                          link_clk;                     // Bit clock
   logic                          arst_n;                       // Reset, active low
   logic                          power_down_n;                 // Power-down, active low
   logic                          tx_en;                        // Transmitter running
   lvds_rx_pkg::pixel_word_t      tx_word;                      // Word being sent
   lvds_rx_pkg::pixel_word_t      parallel_data_out;            // Received word
   logic [lvds_rx_pkg::LANES-1:0] serial_data_lane;             // Data lanes
   logic                          link_clock_in;                // Forwarded clock lane
   logic                          pixel_clock_out;              // Regenerated clock
   logic                          lock_status;                  // Lock flag
   int                            err_total;                    // Mismatches
   int                            n_checks;                     // Comparisons

   // System clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Bit clock, offset so its edges wander against clk
   initial begin
      link_clk = 1'b0;
      #3;
      forever #(LINK_NS/2) link_clk = ~link_clk;
   end

   lvds_video_deserializer_rx #(.LOCK_CYCLES(20)) DUT (
      .clk               (clk),
      .arst_n            (arst_n),
      .link_clk          (link_clk),
      .serial_data_lane  (serial_data_lane),
      .link_clock_in     (link_clock_in),
      .power_down_n      (power_down_n),
      .parallel_data_out (parallel_data_out),
      .pixel_clock_out   (pixel_clock_out),
      .lock_status       (lock_status)
   );

   lvds_tx_model u_tx (
      .link_clk         (link_clk),
      .en               (tx_en),
      .word             (tx_word),
      .serial_data_lane (serial_data_lane),
      .link_clock_in    (link_clock_in)
   );

   // Counts a comparison and reports a mismatch
   task automatic check(input bit ok, input string msg);
      n_checks++;
      if (!ok) begin
         err_total++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : check

   // Prints the verdict and stops
   task automatic wrap_up();
      if (err_total == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // Waits for lock, checking the outputs stay quiet meanwhile
   task automatic wait_lock();
      int i;
      bit quiet;
      i     = 0;
      quiet = 1'b1;
      while (lock_status !== 1'b1 && i < 400) begin
         @(posedge clk);
         #1;
         if (lock_status !== 1'b1) begin
            quiet &= (parallel_data_out === '0) && (pixel_clock_out === 1'b0);
         end
         i++;
      end
      check(quiet, "outputs active before lock");
      check(lock_status === 1'b1, "lock not reached");
   endtask : wait_lock

   // Sends one-hot and mixed words and compares the received word and fields
   task automatic t_mapping();
      logic [27:0] pats [4];
      pats = '{28'h0000001, 28'h8000000, 28'h5A5A5A5, 28'h3C0FF0E};
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         tx_word <= pats[k];
         repeat (3) @(negedge pixel_clock_out);
         check(parallel_data_out === pats[k], "word mismatch");
         check(parallel_data_out.red === pats[k][7:0], "red");
         check(parallel_data_out.green === pats[k][15:8], "green");
         check(parallel_data_out.blue === pats[k][23:16], "blue");
         check({parallel_data_out.data_enable_flag, parallel_data_out.frame_sync,
                parallel_data_out.line_sync} === pats[k][26:24], "syncs");
      end
   endtask : t_mapping

   // Measures pixel clock phases and word stability around the strobe
   task automatic t_clock_shape();
      realtime t0;
      realtime t1;
      realtime t2;
      lvds_rx_pkg::pixel_word_t w0;
      @(posedge clk);
      tx_word <= 28'h6B1D2C7;
      @(posedge pixel_clock_out);
      t0 = $realtime;
      #1 w0 = parallel_data_out;
      @(negedge pixel_clock_out);
      t1 = $realtime;
      check(parallel_data_out === w0, "word moved before strobe");
      @(posedge pixel_clock_out);
      t2 = $realtime;
      check(t1 - t0 == lvds_rx_pkg::HIGH_SLOTS * LINK_NS, "high time");
      check(t2 - t1 == LOW_NS, "low time");
      check(t2 - t0 == lvds_rx_pkg::SLOTS * LINK_NS, "period");
   endtask : t_clock_shape

   // Power-down forces everything low quickly, then the link recovers
   task automatic t_power_down();
      @(posedge clk);
      power_down_n <= 1'b0;
      tx_en        <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(parallel_data_out === '0, "word not low in power-down");
      check(pixel_clock_out === 1'b0, "clock not low");
      repeat (3) @(posedge clk);
      #1;
      check(lock_status === 1'b0, "lock kept in power-down");
      repeat (30) @(posedge clk);
      check(parallel_data_out === '0, "word rose in power-down");
      power_down_n <= 1'b1;
      tx_en        <= 1'b1;
      wait_lock();
      repeat (3) @(negedge pixel_clock_out);
      check(parallel_data_out === tx_word, "word after recovery");
   endtask : t_power_down

   // A silent link loses lock and quiets the outputs
   task automatic t_idle();
      int i;
      @(posedge clk);
      tx_en <= 1'b0;
      i = 0;
      while (lock_status !== 1'b0 && i < 60) begin
         @(posedge clk);
         i++;
      end
      repeat (4) @(posedge clk);
      #1;
      check(lock_status === 1'b0, "lock kept on idle link");
      check(parallel_data_out === '0, "word kept unlocked");
      @(posedge clk);
      tx_en <= 1'b1;
      wait_lock();
   endtask : t_idle

   // Main sequence
   initial begin
      err_total    = 0;
      n_checks     = 0;
      arst_n       = 1'b0;
      power_down_n = 1'b1;
      tx_en        = 1'b0;
      tx_word      = '0;
      repeat (3) @(posedge clk);
      arst_n  <= 1'b1;
      tx_en   <= 1'b1;
      tx_word <= 28'h1234567;
      wait_lock();
      t_mapping();
      t_clock_shape();
      t_power_down();
      t_idle();
      wrap_up();
   end

   // Cuts a hang short
   initial begin
      #100000;
      err_total++;
      wrap_up();
   end
endmodule : lvds_video_deserializer_rx_tb
